/* hdl/list_step_trigger_wait_regs.vh */
// constants for the list step trigger wait block
`ifndef LIST_STEP_TRIGGER_WAIT_REGS_VH
`define LIST_STEP_TRIGGER_WAIT_REGS_VH
`define CLK_MHZ 125
`define HIGH_STABLE_NS 400000
`define LOW_STABLE_NS 2000
`define HIGH_STABLE_CYC ((`HIGH_STABLE_NS * `CLK_MHZ + 999) / 1000)
`define LOW_STABLE_CYC ((`LOW_STABLE_NS * `CLK_MHZ + 999) / 1000)
`define STEP_HIGH 2'h0
`define STEP_LOW 2'h1
`define STEP_FALL 2'h2
`define STEP_NONE 2'h3
`define ERR_NONE 16'h0000
`define ERR_CONFLICT 16'h00dd
`define ERR_RANGE 16'h00de
`define ERR_LEN_SAME 16'h00e2
`define ERR_UNBAL 16'h00ec
`define ANGLE_FULL 16'h8ca0
`define ANGLE_MIN 16'h0001
`define POINTER_RESET 8'h00
`endif

/* hdl/trigger_filter.v */
// level filter for the trigger pin, two stage sync plus stability counter
`timescale 1ns/1ns
module trigger_filter #(
  parameter CW = 16
)
(
  input wire clk,
  input wire reset_n,
  input wire pin,
  input wire [CW-1:0] need,
  output reg level_r
);
  reg s1_r;
  reg s2_r;
  reg [CW-1:0] cnt_r;
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      cnt_r <= {CW{1'b0}};
      level_r <= 1'b0;
    end
    else
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      if (s2_r == level_r)
        cnt_r <= {CW{1'b0}};
      else if (cnt_r + 1'b1 >= need)
      begin
        level_r <= s2_r;
        cnt_r <= {CW{1'b0}};
      end
      else
        cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule // trigger_filter

/* hdl/list_step_trigger_wait.v */
// list step sequencer for trigger waits, point counter, angles and error codes
`timescale 1ns/1ns
`include "list_step_trigger_wait_regs.vh"
// Functional notes
// R01: each wait step drives its programmed level immediately on start.
// R02: wait-high with trigger already high and nonzero wait skips at once.
// R03: wait-high advances on trigger high or nonzero wait expiry, first wins.
// R04: wait-high with zero wait time never times out.
// R05: wait-high accepts trigger level after 0.4 ms of stability.
// R06: falling-edge step ignores an already-low input, needs high then low.
// R07: falling-edge step advances on falling edge or nonzero wait expiry.
// R08: falling-edge step with zero wait holds until a falling edge.
// R09: wait-low with trigger already low and nonzero wait skips at once.
// R10: wait-low advances on trigger low or nonzero wait expiry, first wins.
// R11: wait-low with zero wait time stays until trigger goes low.
// R12: wait-low treats trigger level stable after 2 us.
// R13: wait step with no prior level entry is refused with code 221.
// R14: high or falling-edge step with unequal list lengths posts code 226.
// R15: low step with unequal list lengths posts code 236.
// R16: point pointer clears to zero, counts entries, query returns it.
// R17: point count query while current list has entries posts code 221.
// R18: start and optional stop angle kept, stop defaults to 360 degrees.
// R19: angle query returns start and stop within 0.01 to 360 degrees.
// R20: output level above model maximum is refused with code 222.
// R21: level command in current mode loads both protection limits.
// R22: wait countdown starts at each wait step and clears on advance.
// R23: outside party keeps trigger pulses between 50 us and 1 ms.
module list_step_trigger_wait #(
  parameter LW = 16,
  parameter TW = 32,
  parameter PW = 8,
  parameter [LW-1:0] LEVEL_MAX = 16'h7fff,
  parameter HIGH_STABLE = `HIGH_STABLE_CYC,
  parameter LOW_STABLE = `LOW_STABLE_CYC
)
(
  input wire clk,
  input wire reset_n,
  input wire trigger_pin,
  input wire step_start,
  input wire [1:0] step_kind,
  input wire [LW-1:0] step_level,
  input wire [TW-1:0] wait_cycles,
  input wire voltage_entries_exist,
  input wire current_level_list_entry,
  input wire dwell_len_match,
  input wire list_clear,
  input wire voltage_point_enter,
  input wire voltage_point_count_query,
  input wire waveform_angle_setting,
  input wire stop_angle_given,
  input wire [15:0] start_angle,
  input wire [15:0] stop_angle,
  input wire level_set,
  input wire [LW-1:0] level_value,
  input wire current_mode,
  output reg [LW-1:0] out_level_r,
  output reg step_busy_r,
  output reg step_advance_r,
  output reg step_timeout_r,
  output reg [PW-1:0] point_count_r,
  output reg count_valid_r,
  output reg [15:0] start_angle_r,
  output reg [15:0] stop_angle_r,
  output reg [LW-1:0] voltage_protection_limits_pos_r,
  output reg [LW-1:0] voltage_protection_limits_neg_r,
  output reg [15:0] err_code_r,
  output reg err_post_r
);
  // ==========================================================
  // trigger filters
  wire trig_hi_lvl;
  wire trig_lo_lvl;
  trigger_filter #(.CW(20)) u_filt_high (
    .clk(clk),
    .reset_n(reset_n),
    .pin(trigger_pin),
    .need(HIGH_STABLE[19:0]), // R05
    .level_r(trig_hi_lvl)
  );
  trigger_filter #(.CW(20)) u_filt_low (
    .clk(clk),
    .reset_n(reset_n),
    .pin(trigger_pin),
    .need(LOW_STABLE[19:0]), // R12
    .level_r(trig_lo_lvl)
  );
  // ==========================================================
  // step sequencer
  localparam S_IDLE = 2'd0;
  localparam S_WAIT = 2'd1;
  reg [1:0] state_r;
  reg [1:0] kind_r;
  reg [TW-1:0] wait_r;
  reg [TW-1:0] timer_r;
  reg armed_r;
  reg lo_prev_r;
  wire timed = (wait_r != {TW{1'b0}});
  wire expired = timed && (timer_r + 1'b1 >= wait_r);
  wire fall = lo_prev_r && !trig_lo_lvl;
  reg done;
  always @*
  begin
    done = 1'b0;
    case (kind_r)
      `STEP_HIGH: done = trig_hi_lvl || expired; // R03 R04
      `STEP_LOW: done = !trig_lo_lvl || expired; // R10 R11
      `STEP_FALL: done = (armed_r && fall) || expired; // R06 R07 R08
      default: done = 1'b1;
    endcase
  end
  // refuse a step with no level list, or with unequal lengths
  wire no_list = !(voltage_entries_exist || current_level_list_entry);
  wire bad_len = !dwell_len_match;
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_r <= S_IDLE;
      kind_r <= `STEP_HIGH;
      wait_r <= {TW{1'b0}};
      timer_r <= {TW{1'b0}};
      armed_r <= 1'b0;
      lo_prev_r <= 1'b0;
      out_level_r <= {LW{1'b0}};
      step_busy_r <= 1'b0;
      step_advance_r <= 1'b0;
      step_timeout_r <= 1'b0;
    end
    else
    begin
      lo_prev_r <= trig_lo_lvl;
      step_advance_r <= 1'b0;
      step_timeout_r <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (step_start && !no_list && !bad_len && step_kind != `STEP_NONE)
          begin
            out_level_r <= step_level; // R01
            kind_r <= step_kind;
            wait_r <= wait_cycles;
            timer_r <= {TW{1'b0}}; // R22
            armed_r <= (step_kind == `STEP_FALL) ? trig_lo_lvl : 1'b0;
            if (wait_cycles != {TW{1'b0}} &&
                ((step_kind == `STEP_HIGH && trig_hi_lvl) || // R02
                 (step_kind == `STEP_LOW && !trig_lo_lvl))) // R09
              step_advance_r <= 1'b1;
            else
            begin
              state_r <= S_WAIT;
              step_busy_r <= 1'b1;
            end
          end
        end
        S_WAIT:
        begin
          if (trig_lo_lvl)
            armed_r <= 1'b1; // R06
          if (done)
          begin
            state_r <= S_IDLE;
            step_busy_r <= 1'b0;
            step_advance_r <= 1'b1;
            step_timeout_r <= expired;
            timer_r <= {TW{1'b0}}; // R22
          end
          else if (timed)
            timer_r <= timer_r + 1'b1;
        end
        default:
        begin
          state_r <= S_IDLE;
          step_busy_r <= 1'b0;
        end
      endcase
    end
  end
  // ==========================================================
  // point counter, angles, protection limits, error codes
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      point_count_r <= `POINTER_RESET;
      count_valid_r <= 1'b0;
      start_angle_r <= `ANGLE_MIN;
      stop_angle_r <= `ANGLE_FULL;
      voltage_protection_limits_pos_r <= {LW{1'b0}};
      voltage_protection_limits_neg_r <= {LW{1'b0}};
      err_code_r <= `ERR_NONE;
      err_post_r <= 1'b0;
    end
    else
    begin
      err_post_r <= 1'b0;
      count_valid_r <= voltage_point_count_query; // R16
      if (list_clear)
        point_count_r <= `POINTER_RESET; // R16
      else if (voltage_point_enter)
        point_count_r <= point_count_r + 1'b1; // R16
      if (waveform_angle_setting)
      begin
        if (start_angle >= `ANGLE_MIN && start_angle <= `ANGLE_FULL) // R19
          start_angle_r <= start_angle;
        if (!stop_angle_given)
          stop_angle_r <= `ANGLE_FULL; // R18
        else if (stop_angle >= `ANGLE_MIN && stop_angle <= `ANGLE_FULL) // R19
          stop_angle_r <= stop_angle;
      end
      if (level_set && level_value <= LEVEL_MAX && current_mode)
      begin
        voltage_protection_limits_pos_r <= level_value; // R21
        voltage_protection_limits_neg_r <= level_value; // R21
      end
      if (state_r == S_IDLE && step_start && no_list)
      begin
        err_code_r <= `ERR_CONFLICT; // R13
        err_post_r <= 1'b1;
      end
      else if (state_r == S_IDLE && step_start && bad_len)
      begin
        err_code_r <= (step_kind == `STEP_LOW) ? `ERR_UNBAL : `ERR_LEN_SAME; // R14 R15
        err_post_r <= 1'b1;
      end
      else if (voltage_point_count_query && current_level_list_entry)
      begin
        err_code_r <= `ERR_CONFLICT; // R17
        err_post_r <= 1'b1;
      end
      else if (level_set && level_value > LEVEL_MAX)
      begin
        err_code_r <= `ERR_RANGE; // R20
        err_post_r <= 1'b1;
      end
    end
  end
endmodule // list_step_trigger_wait

/* tb/lstw_checker.sv */
// port assertions for the list step trigger wait block
`timescale 1ns/1ns
module lstw_checker #(
  parameter LW = 16,
  parameter PW = 8,
  parameter [LW-1:0] LEVEL_MAX = 16'h7fff
)
(
  input wire clk,
  input wire reset_n,
  input wire step_start,
  input wire [1:0] step_kind,
  input wire [LW-1:0] step_level,
  input wire voltage_entries_exist,
  input wire current_level_list_entry,
  input wire dwell_len_match,
  input wire list_clear,
  input wire voltage_point_enter,
  input wire voltage_point_count_query,
  input wire level_set,
  input wire [LW-1:0] level_value,
  input wire current_mode,
  input wire [LW-1:0] out_level_r,
  input wire step_busy_r,
  input wire step_advance_r,
  input wire step_timeout_r,
  input wire [PW-1:0] point_count_r,
  input wire [LW-1:0] voltage_protection_limits_pos_r,
  input wire [LW-1:0] voltage_protection_limits_neg_r,
  input wire [15:0] err_code_r
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ==========
  // step requests, point pointer and level commands
  sequence s_take;
    step_start && !step_busy_r && step_kind != 2'b11;
  endsequence
  sequence s_bad_len;
    s_take ##0 ((voltage_entries_exist || current_level_list_entry) && !dwell_len_match);
  endsequence
  AST_LEVEL: assert property ((s_take ##0
    ((voltage_entries_exist || current_level_list_entry) && dwell_len_match))
    |=> out_level_r == $past(step_level)) else $error("step level not driven");
  AST_NOLIST: assert property ((s_take ##0
    (!voltage_entries_exist && !current_level_list_entry))
    |=> err_code_r == 16'd221) else $error("missing list not refused");
  AST_LEN: assert property ((s_bad_len ##0 step_kind != 2'b01)
    |=> err_code_r == 16'd226) else $error("length code wrong");
  AST_UNBAL: assert property ((s_bad_len ##0 step_kind == 2'b01)
    |=> err_code_r == 16'd236) else $error("unbalanced code wrong");
  AST_TIMEOUT: assert property (step_timeout_r |-> step_advance_r && !step_busy_r)
    else $error("timeout without advance");
  AST_CLEAR: assert property (list_clear |=> point_count_r == '0)
    else $error("pointer not cleared");
  AST_COUNT: assert property (voltage_point_enter && !list_clear
    |=> point_count_r == $past(point_count_r) + 1'b1) else $error("pointer not counted");
  AST_PROT: assert property (level_set && current_mode && level_value <= LEVEL_MAX
    |=> voltage_protection_limits_pos_r == $past(level_value)
    && voltage_protection_limits_neg_r == $past(level_value)) else $error("limits not loaded");
  AST_RANGE: assert property (level_set && level_value > LEVEL_MAX && !step_start
    && !voltage_point_count_query |=> err_code_r == 16'd222
    && $stable(voltage_protection_limits_pos_r)) else $error("range not refused");
endmodule // lstw_checker
bind list_step_trigger_wait lstw_checker #(.LW(LW), .PW(PW), .LEVEL_MAX(LEVEL_MAX)) u_chk (.*);

/* tb/trigger_host.sv */
// host model driving the trigger input
`timescale 1ns/1ns
module trigger_host (
  input wire clk,
  output reg trigger_pin
);
  initial trigger_pin = 1'b0;
  task automatic set_level(input logic v);
    @(posedge clk);
    #1 trigger_pin = v;
  endtask
  // pulse length kept above the low filter time
  task automatic pulse(input int n);
    set_level(1'b1);
    repeat (n) @(posedge clk);
    set_level(1'b0);
  endtask
endmodule // trigger_host

/* tb/tb_top.sv */
// self-checking bench for the list step trigger wait block
`timescale 1ns/1ns
module tb_top;
  logic clk = 0, reset_n = 0, step_start = 0, voltage_entries_exist = 1;
  logic current_level_list_entry = 0, dwell_len_match = 1, list_clear = 0;
  logic voltage_point_enter = 0, voltage_point_count_query = 0, waveform_angle_setting = 0;
  logic stop_angle_given = 0, level_set = 0, current_mode = 0, to;
  logic [1:0] step_kind = 0;
  logic [15:0] step_level = 0, start_angle = 0, stop_angle = 0, level_value = 0;
  logic [31:0] wait_cycles = 0;
  wire [15:0] out_level_r, start_angle_r, stop_angle_r, err_code_r;
  wire [15:0] voltage_protection_limits_pos_r, voltage_protection_limits_neg_r;
  wire [7:0] point_count_r;
  wire trigger_pin, step_busy_r, step_advance_r, step_timeout_r, count_valid_r, err_post_r;
  int n_errors = 0, n_checks = 0, cyc = 0, n;
  always #4 clk = ~clk;
  list_step_trigger_wait #(.HIGH_STABLE(20), .LOW_STABLE(4)) u_list_step_trigger_wait (.*);
  trigger_host u_trigger_host (.clk(clk), .trigger_pin(trigger_pin));
  // ==========
  // helpers
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", s, e, g);
    end
  endtask
  task automatic start(input logic [1:0] k, input logic [15:0] l, input int w);
    step_kind = k;
    step_level = l;
    wait_cycles = w;
    step_start = 1;
    tick;
    step_start = 0;
  endtask
  task automatic wadv(input int lim);
    n = 0;
    while (step_advance_r !== 1'b1 && n < lim)
    begin
      tick;
      n++;
    end
    to = step_timeout_r;
  endtask
  task automatic pulse_in(ref logic s);
    s = 1;
    tick;
    s = 0;
    tick;
  endtask
  // ==========
  // scenarios
  task automatic t_waits;
    start(2'b00, 16'h0123, 0);
    chk("level", 16'h0123, out_level_r);
    chk("busy", 1, step_busy_r);
    wadv(40);
    chk("hold", 40, n);
    u_trigger_host.set_level(1'b1);
    wadv(60);
    chk("filter", 1, n >= 20 && n < 60);
    chk("no_to", 0, to);
    start(2'b00, 16'h0456, 50);
    wadv(4);
    chk("skip_hi", 1, n < 4);
    start(2'b01, 16'h0789, 10);
    wadv(30);
    chk("low_to", 1, to);
    chk("to_cnt", 1, n >= 9 && n <= 11);
    u_trigger_host.set_level(1'b0);
    repeat (10) tick;
    start(2'b01, 16'h0011, 50);
    wadv(4);
    chk("skip_lo", 1, n < 4);
    start(2'b10, 16'h0abc, 0);
    wadv(30);
    chk("no_edge", 30, n);
    u_trigger_host.pulse(8);
    wadv(30);
    chk("edge", 1, n < 30);
    start(2'b10, 16'h0def, 10);
    wadv(30);
    chk("edge_to", 1, to);
    u_trigger_host.set_level(1'b1);
    repeat (10) tick;
    start(2'b01, 16'h0022, 0);
    wadv(20);
    chk("lo_hold", 20, n);
    u_trigger_host.set_level(1'b0);
    wadv(20);
    chk("lo_filt", 1, n >= 4 && n < 20);
    chk("lo_no_to", 0, to);
    repeat (30) tick;
    $display("waits done");
  endtask
  task automatic t_lists;
    voltage_entries_exist = 0;
    start(2'b00, 16'h0001, 0);
    chk("nolist", 221, err_code_r);
    voltage_entries_exist = 1;
    dwell_len_match = 0;
    for (int k = 0; k < 3; k++)
    begin
      start(k[1:0], 16'h0001, 0);
      tick;
      chk("len", (k == 1) ? 236 : 226, err_code_r);
    end
    dwell_len_match = 1;
    current_level_list_entry = 1;
    voltage_point_count_query = 1;
    tick;
    chk("cvalid", 1, count_valid_r);
    chk("post", 1, err_post_r);
    chk("q_conf", 221, err_code_r);
    voltage_point_count_query = 0;
    tick;
    chk("cvalid_end", 0, count_valid_r);
    current_level_list_entry = 0;
    pulse_in(list_clear);
    voltage_point_enter = 1;
    repeat (3) tick;
    pulse_in(voltage_point_enter);
    chk("points", 4, point_count_r);
    $display("lists done");
  endtask
  task automatic t_angle_level;
    start_angle = 16'd100;
    stop_angle = 16'd500;
    pulse_in(waveform_angle_setting);
    chk("start", 100, start_angle_r);
    chk("stop_def", 36000, stop_angle_r);
    stop_angle_given = 1;
    stop_angle = 16'd18000;
    pulse_in(waveform_angle_setting);
    chk("stop", 18000, stop_angle_r);
    current_mode = 1;
    level_value = 16'h1234;
    pulse_in(level_set);
    chk("pos", 16'h1234, voltage_protection_limits_pos_r);
    chk("neg", 16'h1234, voltage_protection_limits_neg_r);
    level_value = 16'h8000;
    pulse_in(level_set);
    chk("range", 222, err_code_r);
    chk("pos_kept", 16'h1234, voltage_protection_limits_pos_r);
    $display("angle and level done");
  endtask
  // ==========
  // run control
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      $display("[ERR] run limit expected done seen hang");
      complete_run;
    end
  end
  initial
  begin
    repeat (16) tick;
    reset_n = 1;
    chk("rst_stop", 36000, stop_angle_r);
    t_waits;
    t_lists;
    t_angle_level;
    complete_run;
  end
endmodule // tb_top
